// ===== rtl/fcp_regs.svh
// Offsets, command codes, status bits and timing of the flash command block
// Assumes a 125 MHz bus clock and a 12-bit register offset decode
`ifndef FCP_REGS_SVH
`define FCP_REGS_SVH

`define FCP_OFS_ADDR      12'h000
`define FCP_OFS_DATA      12'h004
`define FCP_OFS_BCR       12'h008
`define FCP_OFS_STATE     12'h00C

`define FCP_CMD_READ      8'hFF
`define FCP_CMD_STATUS    8'h70
`define FCP_CMD_SIG       8'h90
`define FCP_CMD_CLR_SR    8'h50
`define FCP_CMD_RESUME    8'hD0
`define FCP_CMD_CFG_SETUP 8'h60
`define FCP_CMD_BCR_CONF  8'h03
`define FCP_CMD_PROT_SET  8'h01
`define FCP_CMD_PROT_CLR  8'hD0
`define FCP_CMD_UNLOCK    8'h78
`define FCP_CMD_PW_PGM    8'h48

`define FCP_SR_READY      7
`define FCP_SR_CFG_ERR    5
`define FCP_SR_PGM_ERR    4
`define FCP_SR_PROGRAM_ERASE_ENABLE_PIN_ERR   3
`define FCP_SR_UNLOCKED   0

`define FCP_TP_ADDR_LO    20'h0_0000
`define FCP_TP_ADDR_HI    20'h0_0001
`define FCP_SIG_MFR       20'h0_0000
`define FCP_SIG_DEV       20'h0_0001
`define FCP_SIG_BCR       20'h0_0005
`define FCP_SIG_PROT      14'h0002

`define FCP_BCR_RESET     16'h0000
`define FCP_CLK_NS        8
`define FCP_STORE_NS      100
`define FCP_PROG_NS       1000

`endif

// ===== rtl/fcp_pkg.sv
// Types of the flash command block
// Assumes fcp_regs.svh for the numeric constants
package fcp_pkg;

  typedef enum logic [2:0] {
    FCP_S_READ     = 3'b000,
    FCP_S_STATUS   = 3'b001,
    FCP_S_SIG      = 3'b011,
    FCP_S_SET60    = 3'b010,
    FCP_S_PW_SETUP = 3'b110,
    FCP_S_PW_BUSY  = 3'b111,
    FCP_S_PW_WAIT  = 3'b101,
    FCP_S_PW_DONE  = 3'b100
  } fcp_state_t;

  typedef struct packed {
    logic       async_mode;
    logic [3:0] spare;
    logic [3:0] x_latency;
    logic [2:0] y_latency;
    logic       burst_type;
    logic [2:0] burst_length;
  } fcp_bcr_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] ofs;
  } fcp_aphase_t;

endpackage

// ===== rtl/fcp_cmd.sv
// Flash command interpreter: resume, burst config, tuning lock, protection
// Assumes an AHB-Lite master, one slave on the bus, pins synchronous to hclk
//
// Functional notes
// - Resume command pulses the controller restart while it is suspended.
// - Burst config takes a setup write, then a confirm carrying the value.
// - Unconfirmed config or protect sequence sets status bits 4 and 5.
// - Burst config load returns the device to array read.
// - Burst config value comes from address bits 15 to 0.
// - Burst config fields drive length, type, latencies and sync mode.
// - After reset tuning is locked; program inhibited, new password refused.
// - During unlock or password program all reads return status.
// - Status bit 7 rises once each password half is stored.
// - After the second half, status bit 0 shows the unlocked state.
// - Wrong password locks the device and sets status bit 4.
// - Enable pin low or reset pin low aborts unlock or program.
// - Unlocked until the next reset or a failed unlock; only read array leaves the sequence.
// - Password program sets status bit 4 when it fails.
// - New password becomes active only at the next reset pin pulse; hresetn restores PW_DEFAULT.
// - Protect sequence marks a block; protected blocks blocked while WP low.
// - Every block starts protected.
// - One block per sequence; reprotecting leaves the state unchanged.
// - Clear sequence unprotects the block regardless of WP.
// - Signature read at block start plus 2 returns the protection bit.
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "fcp_regs.svh"

module fcp_cmd
  import fcp_pkg::*;
#(
  parameter int          NUM_BLOCKS = 64,
  parameter logic [31:0] MFR_CODE   = 32'h0000_00A5, // Arbitrary value
  parameter logic [31:0] DEV_CODE   = 32'h0000_5A5A, // Arbitrary value
  parameter logic [63:0] PW_DEFAULT = 64'h0000_0000_0000_0000
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        program_erase_enable_pin,
  input  wire logic        reset_powerdown_pin,
  input  wire logic        write_protect_n,
  input  wire logic        pe_suspended,
  input  wire logic [31:0] array_rdata,
  input  wire logic [19:0] target_addr,
  output logic             pe_resume,
  output logic      [19:0] array_addr,
  output fcp_bcr_t         burst_cfg,
  output logic             tuning_unlocked,
  output logic             target_inhibit
);

  localparam int BLK_W = $clog2(NUM_BLOCKS);
  localparam int STORE_CYC = (`FCP_STORE_NS + `FCP_CLK_NS - 1) / `FCP_CLK_NS;
  localparam int PROG_CYC = (`FCP_PROG_NS + `FCP_CLK_NS - 1) / `FCP_CLK_NS;
  localparam int MAX_WAIT = PROG_CYC + 2;

  fcp_aphase_t           aph;
  fcp_state_t            state;
  fcp_state_t            next_state;
  logic                  op_pgm;
  logic                  half;
  logic [7:0]            cnt;
  logic [63:0]           pw_buf;
  logic [63:0]           pw_active;
  logic [63:0]           pw_pending;
  logic                  cfg_err;
  logic                  pgm_err;
  logic                  program_erase_enable_pin_err;
  logic [NUM_BLOCKS-1:0] prot;
  logic                  fwr;
  logic [7:0]            cmd;
  logic [7:0]            sr;
  logic [31:0]           flash_rdata;
  logic                  in_pw;
  logic                  pw_done;
  logic                  pw_match;
  logic                  ev_cfg_err;
  logic                  ev_pgm_err;
  logic                  ev_clr_sr;
  logic                  ev_resume;
  logic                  ev_bcr;
  logic                  ev_prot_set;
  logic                  ev_prot_clr;
  logic                  ev_store;

  function automatic logic [BLK_W-1:0] blk_of(input logic [19:0] a);
    blk_of = a[19 -: BLK_W];
  endfunction

  assign fwr      = aph.wr && aph.ofs == `FCP_OFS_DATA;
  assign cmd      = hwdata[7:0];
  assign in_pw    = state inside {FCP_S_PW_SETUP, FCP_S_PW_BUSY,
                                  FCP_S_PW_WAIT};
  assign pw_done  = state == FCP_S_PW_BUSY && half && cnt == 8'h00;
  assign pw_match = pw_buf == pw_active;
  assign sr = {state != FCP_S_PW_BUSY, 1'b0, cfg_err, pgm_err, program_erase_enable_pin_err,
               2'b00, tuning_unlocked};

  // Bus slave: writes zero wait, reads one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph       <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else if (hready) begin
      aph.wr    <= hsel && htrans[1] && hwrite;
      aph.rd    <= hsel && htrans[1] && !hwrite;
      aph.ofs   <= {haddr[11:2], 2'b00};
      hreadyout <= !(hsel && htrans[1] && !hwrite);
    end else if (aph.rd) begin
      aph.rd    <= 1'b0;
      hreadyout <= 1'b1;
      unique case (aph.ofs)
        `FCP_OFS_ADDR:  hrdata <= {12'h000, array_addr};
        `FCP_OFS_DATA:  hrdata <= flash_rdata;
        `FCP_OFS_BCR:   hrdata <= {16'h0000, burst_cfg};
        `FCP_OFS_STATE: hrdata <= {29'h0000_0000, state};
        default:        hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      array_addr <= 20'h0_0000;
    end else if (aph.wr && aph.ofs == `FCP_OFS_ADDR) begin
      array_addr <= hwdata[19:0];
    end
  end

  // Flash side read data by mode
  always_comb begin
    flash_rdata = {24'h00_0000, sr};
    unique case (state)
      FCP_S_READ: flash_rdata = array_rdata;
      FCP_S_SIG: begin
        if (array_addr == `FCP_SIG_MFR)
          flash_rdata = MFR_CODE;
        else if (array_addr == `FCP_SIG_DEV)
          flash_rdata = DEV_CODE;
        else if (array_addr == `FCP_SIG_BCR)
          flash_rdata = {16'h0000, burst_cfg};
        else if (array_addr[13:0] == `FCP_SIG_PROT)
          flash_rdata = {31'h0000_0000, prot[blk_of(array_addr)]};
        else
          flash_rdata = 32'h0000_0000;
      end
      FCP_S_STATUS, FCP_S_SET60, FCP_S_PW_SETUP, FCP_S_PW_BUSY,
      FCP_S_PW_WAIT, FCP_S_PW_DONE: flash_rdata = {24'h00_0000, sr};
    endcase
  end

  // Command decode
  always_comb begin
    next_state  = state;
    ev_cfg_err  = 1'b0;
    ev_pgm_err  = 1'b0;
    ev_clr_sr   = 1'b0;
    ev_resume   = 1'b0;
    ev_bcr      = 1'b0;
    ev_prot_set = 1'b0;
    ev_prot_clr = 1'b0;
    ev_store    = 1'b0;
    unique case (state)
      FCP_S_READ, FCP_S_STATUS, FCP_S_SIG: begin
        if (fwr) begin
          if (cmd == `FCP_CMD_READ) begin
            next_state = FCP_S_READ;
          end else if (cmd == `FCP_CMD_STATUS) begin
            next_state = FCP_S_STATUS;
          end else if (cmd == `FCP_CMD_SIG) begin
            next_state = FCP_S_SIG;
          end else if (cmd == `FCP_CMD_CLR_SR) begin
            ev_clr_sr = 1'b1;
          end else if (cmd == `FCP_CMD_RESUME && pe_suspended) begin
            ev_resume  = 1'b1;
            next_state = FCP_S_STATUS;
          end else if (cmd == `FCP_CMD_CFG_SETUP) begin
            next_state = FCP_S_SET60;
          end else if (cmd == `FCP_CMD_UNLOCK) begin
            next_state = FCP_S_PW_SETUP;
          end else if (cmd == `FCP_CMD_PW_PGM) begin
            if (tuning_unlocked) begin
              next_state = FCP_S_PW_SETUP;
            end else begin
              ev_pgm_err = 1'b1;
              next_state = FCP_S_STATUS;
            end
          end
        end
      end
      FCP_S_SET60: begin
        if (fwr) begin
          next_state = FCP_S_READ;
          if (cmd == `FCP_CMD_BCR_CONF) begin
            ev_bcr = 1'b1;
          end else if (cmd == `FCP_CMD_PROT_SET) begin
            ev_prot_set = 1'b1;
            next_state  = FCP_S_STATUS;
          end else if (cmd == `FCP_CMD_PROT_CLR) begin
            ev_prot_clr = 1'b1;
            next_state  = FCP_S_STATUS;
          end else begin
            ev_cfg_err = 1'b1;
            ev_pgm_err = 1'b1;
            next_state = FCP_S_STATUS;
          end
        end
      end
      FCP_S_PW_SETUP: begin
        if (fwr) begin
          if (array_addr == (half ? `FCP_TP_ADDR_HI : `FCP_TP_ADDR_LO)) begin
            ev_store   = 1'b1;
            next_state = FCP_S_PW_BUSY;
          end else begin
            ev_cfg_err = 1'b1;
            ev_pgm_err = 1'b1;
            next_state = FCP_S_STATUS;
          end
        end
      end
      FCP_S_PW_BUSY: begin
        if (cnt == 8'h00)
          next_state = half ? FCP_S_PW_DONE : FCP_S_PW_WAIT;
      end
      FCP_S_PW_WAIT: begin
        if (fwr) begin
          if (cmd == (op_pgm ? `FCP_CMD_PW_PGM : `FCP_CMD_UNLOCK)) begin
            next_state = FCP_S_PW_SETUP;
          end else begin
            ev_cfg_err = 1'b1;
            ev_pgm_err = 1'b1;
            next_state = FCP_S_STATUS;
          end
        end
      end
      FCP_S_PW_DONE: begin
        if (fwr && cmd == `FCP_CMD_READ)
          next_state = FCP_S_READ;
      end
    endcase
  end

  // Mode state, with reset pin and enable pin aborts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= FCP_S_READ;
    end else if (!reset_powerdown_pin) begin
      state <= FCP_S_READ;
    end else if (in_pw && !program_erase_enable_pin) begin
      state <= FCP_S_STATUS;
    end else begin
      state <= next_state;
    end
  end

  // Sequence bookkeeping and store timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_pgm <= 1'b0;
      half   <= 1'b0;
      cnt    <= 8'h00;
      pw_buf <= 64'h0000_0000_0000_0000;
    end else if (state != FCP_S_PW_SETUP && next_state == FCP_S_PW_SETUP &&
                 state != FCP_S_PW_WAIT) begin
      op_pgm <= cmd == `FCP_CMD_PW_PGM;
      half   <= 1'b0;
    end else if (ev_store) begin
      if (half)
        pw_buf[63:32] <= hwdata;
      else
        pw_buf[31:0] <= hwdata;
      cnt <= (half && op_pgm) ? 8'(PROG_CYC - 1) : 8'(STORE_CYC - 1);
    end else if (state == FCP_S_PW_BUSY) begin
      if (cnt == 8'h00)
        half <= 1'b1;
      else
        cnt <= cnt - 8'h01;
    end
  end

  // Tuning lock and password storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tuning_unlocked <= 1'b0;
      pw_active       <= PW_DEFAULT;
      pw_pending      <= PW_DEFAULT;
    end else if (!reset_powerdown_pin) begin
      tuning_unlocked <= 1'b0;
      pw_active       <= pw_pending;
    end else if (pw_done && program_erase_enable_pin) begin
      if (op_pgm)
        pw_pending <= pw_buf;
      else
        tuning_unlocked <= pw_match;
    end
  end

  // Status error bits; a new error wins over a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_err  <= 1'b0;
      pgm_err  <= 1'b0;
      program_erase_enable_pin_err <= 1'b0;
    end else if (!reset_powerdown_pin) begin
      cfg_err  <= 1'b0;
      pgm_err  <= 1'b0;
      program_erase_enable_pin_err <= 1'b0;
    end else begin
      if (ev_cfg_err)
        cfg_err <= 1'b1;
      else if (ev_clr_sr)
        cfg_err <= 1'b0;
      if (ev_pgm_err || (pw_done && !op_pgm && !pw_match))
        pgm_err <= 1'b1;
      else if (ev_clr_sr)
        pgm_err <= 1'b0;
      if (in_pw && !program_erase_enable_pin)
        program_erase_enable_pin_err <= 1'b1;
      else if (ev_clr_sr)
        program_erase_enable_pin_err <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_cfg <= fcp_bcr_t'(`FCP_BCR_RESET);
    end else if (ev_bcr && reset_powerdown_pin) begin
      burst_cfg <= fcp_bcr_t'(array_addr[15:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pe_resume <= 1'b0;
    end else begin
      pe_resume <= ev_resume && reset_powerdown_pin;
    end
  end

  // Per-block protection, all protected after power-up
  generate
    for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_prot
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          prot[b] <= 1'b1;
        end else if (reset_powerdown_pin &&
                     blk_of(array_addr) == BLK_W'(b)) begin
          if (ev_prot_set)
            prot[b] <= 1'b1;
          else if (ev_prot_clr)
            prot[b] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      target_inhibit <= 1'b1;
    end else begin
      target_inhibit <= !tuning_unlocked ||
                        (prot[blk_of(target_addr)] && !write_protect_n);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_resume;
    (state == FCP_S_READ && fwr && cmd == `FCP_CMD_RESUME && pe_suspended
     && reset_powerdown_pin) |=> pe_resume ##1 !pe_resume;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume not pulsed");

  property p_bad_confirm;
    (state == FCP_S_SET60 && fwr && reset_powerdown_pin &&
     !(cmd inside {`FCP_CMD_BCR_CONF, `FCP_CMD_PROT_SET, `FCP_CMD_PROT_CLR}))
    |=> sr[5] && sr[4] && state == FCP_S_STATUS;
  endproperty
  a_bad_confirm: assert property (p_bad_confirm)
    else $error("bad confirm not flagged");

  property p_bcr_read;
    (state == FCP_S_SET60 && fwr && cmd == `FCP_CMD_BCR_CONF &&
     reset_powerdown_pin) |=> state == FCP_S_READ &&
     burst_cfg == $past(array_addr[15:0]);
  endproperty
  a_bcr_read: assert property (p_bcr_read)
    else $error("burst config load wrong");

  property p_status_reads;
    (in_pw && aph.rd && !hready && aph.ofs == `FCP_OFS_DATA)
    |=> hrdata == {24'h00_0000, $past(sr)};
  endproperty
  a_status_reads: assert property (p_status_reads)
    else $error("array data during password sequence");

  property p_half_ready;
    (state == FCP_S_PW_SETUP && ev_store) |=> !sr[7] ##[1:MAX_WAIT] sr[7];
  endproperty
  a_half_ready: assert property (p_half_ready)
    else $error("ready bit not raised after half store");

  property p_unlock_result;
    (pw_done && !op_pgm && program_erase_enable_pin && reset_powerdown_pin)
    |=> sr[0] == $past(pw_match) && sr[4] == !$past(pw_match);
  endproperty
  a_unlock_result: assert property (p_unlock_result)
    else $error("unlock result wrong");

  property p_abort;
    (in_pw && !program_erase_enable_pin && reset_powerdown_pin)
    |=> state == FCP_S_STATUS && sr[3];
  endproperty
  a_abort: assert property (p_abort)
    else $error("enable pin abort missed");

  property p_rp_lock;
    !reset_powerdown_pin |=> !tuning_unlocked && state == FCP_S_READ;
  endproperty
  a_rp_lock: assert property (p_rp_lock)
    else $error("reset pin did not relock");

  property p_pw_refuse;
    (state == FCP_S_READ && fwr && cmd == `FCP_CMD_PW_PGM &&
     !tuning_unlocked && reset_powerdown_pin) |=> sr[4] &&
     state == FCP_S_STATUS;
  endproperty
  a_pw_refuse: assert property (p_pw_refuse)
    else $error("password program accepted while locked");

  property p_inhibit;
    (prot[blk_of(target_addr)] && !write_protect_n) |=> target_inhibit;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("protected block not inhibited");

  c_bcr: cover property (ev_bcr ##1 state == FCP_S_READ);
  c_unlock: cover property (pw_done && !op_pgm ##1 tuning_unlocked);
  c_pw_pgm: cover property (pw_done && op_pgm);
  c_prot_clr: cover property (ev_prot_clr);

endmodule // fcp_cmd

// ===== verification/fcp_host.sv
// AHB-Lite master model standing in for the host controller
// Assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/100ps

module fcp_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  output logic             hang
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    hang = 1'b0;
  end

  // Waits for hready sampled high, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) hang <= 1'b1;
  endtask

  // One single word transfer
  task automatic xfer(input logic wr, input logic [11:0] ofs,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
endmodule // fcp_host

// ===== verification/flash_config_protect_commands_bench.sv
// Self-checking bench for the flash command interpreter
// Assumes fcp_host drives the register bus; pins are driven here
`timescale 1ns/100ps
`include "fcp_regs.svh"

module flash_config_protect_commands_bench
  import fcp_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        hang;
  logic        program_erase_enable_pin;
  logic        reset_powerdown_pin;
  logic        write_protect_n;
  logic        pe_suspended;
  logic [31:0] array_rdata;
  logic [19:0] target_addr;
  logic        pe_resume;
  logic [19:0] array_addr;
  fcp_bcr_t    burst_cfg;
  logic        tuning_unlocked;
  logic        target_inhibit;
  logic [31:0] sr;
  logic [31:0] r;
  logic        b;
  int          n_errors;
  int          checks;
  int          n_res;

  fcp_host i_fcp_host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hang);

  fcp_cmd i_fcp_cmd (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .program_erase_enable_pin, .reset_powerdown_pin, .write_protect_n,
    .pe_suspended, .array_rdata, .target_addr, .pe_resume, .array_addr,
    .burst_cfg, .tuning_unlocked, .target_inhibit);

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  always @(posedge hclk) if (pe_resume === 1'b1) n_res++;

  always @(posedge hang) begin
    n_errors++;
    final_report();
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Flash bus write and read through the address and data registers
  task automatic fw(input logic [19:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_fcp_host.xfer(1'b1, `FCP_OFS_ADDR, {12'h000, a}, x);
    i_fcp_host.xfer(1'b1, `FCP_OFS_DATA, d, x);
  endtask

  task automatic fr(input logic [19:0] a, output logic [31:0] d);
    logic [31:0] x;
    i_fcp_host.xfer(1'b1, `FCP_OFS_ADDR, {12'h000, a}, x);
    i_fcp_host.xfer(1'b0, `FCP_OFS_DATA, 32'h0000_0000, d);
  endtask

  // Status bits 7, 4, 3, 0 against an expected nibble
  task automatic sr_chk(input logic [3:0] e);
    fr(20'h0_0000, sr);
    chk({28'h000_0000, sr[7], sr[4], sr[3], sr[0]}, {28'h000_0000, e});
  endtask

  task automatic poll(input logic [19:0] a, output logic first);
    int n;
    fr(a, sr);
    first = sr[7];
    n = 0;
    while (sr[7] !== 1'b1 && n < 100) begin
      fr(a, sr);
      n++;
    end
    if (sr[7] !== 1'b1) begin
      n_errors++;
      final_report();
    end
  endtask

  // Four-write password sequence with the given setup code
  task automatic seq(input logic [7:0] c, input logic [63:0] pw,
                     output logic b7);
    logic f;
    fw(20'h0_0000, {24'h00_0000, c});
    fw(`FCP_TP_ADDR_LO, pw[31:0]);
    poll(`FCP_TP_ADDR_LO, b7);
    fw(20'h0_0000, {24'h00_0000, c});
    fw(`FCP_TP_ADDR_HI, pw[63:32]);
    poll(`FCP_TP_ADDR_HI, f);
  endtask

  task automatic rp_pulse();
    reset_powerdown_pin <= 1'b0;
    repeat (2) @(posedge hclk);
    reset_powerdown_pin <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask

  task automatic t_reset();
    chk({16'h0000, burst_cfg}, 32'h0000_0000);
    chk({31'h0, tuning_unlocked}, 32'h0000_0000);
    chk({31'h0, target_inhibit}, 32'h0000_0001);
    $display("reset test done");
  endtask

  task automatic t_bcr();
    fw(20'h0_0000, 32'h0000_0060);
    fw(20'hF_5A3C, 32'h0000_0003);
    chk({12'h000, array_addr}, 32'h000F_5A3C);
    i_fcp_host.xfer(1'b0, `FCP_OFS_BCR, 32'h0000_0000, r);
    chk(r, 32'h0000_5A3C);
    chk({31'h0, hresp}, 32'h0000_0000);
    chk({16'h0000, burst_cfg}, 32'h0000_5A3C);
    chk({29'h0, burst_cfg.burst_length}, 32'h0000_0004);
    i_fcp_host.xfer(1'b0, `FCP_OFS_STATE, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    fr(20'h0_0000, r);
    chk(r, 32'h1357_9BDF);
    fw(20'h0_0000, 32'h0000_0060);
    fw(20'h0_0000, 32'h0000_0077);
    sr_chk(4'b1100);
    chk({31'h0, sr[5]}, 32'h0000_0001);
    fw(20'h0_0000, 32'h0000_0050);
    fw(20'h0_0000, 32'h0000_00FF);
    fw(20'h0_0000, 32'h0000_0070);
    fr(20'h0_0000, r);
    chk(r, 32'h0000_0080);
    $display("burst config test done");
  endtask

  task automatic t_resume();
    pe_suspended <= 1'b1;
    fw(20'h0_0000, 32'h0000_00D0);
    repeat (2) @(posedge hclk);
    chk(n_res, 32'h0000_0001);
    pe_suspended <= 1'b0;
    fw(20'h0_0000, 32'h0000_00D0);
    repeat (2) @(posedge hclk);
    chk(n_res, 32'h0000_0001);
    $display("resume test done");
  endtask

  task automatic t_unlock();
    fw(20'h0_0000, 32'h0000_0048);
    sr_chk(4'b1100);
    rp_pulse();
    seq(8'h78, 64'h0, b);
    chk({31'h0, b}, 32'h0000_0000);
    sr_chk(4'b1001);
    chk({31'h0, tuning_unlocked}, 32'h0000_0001);
    fw(20'h0_0000, 32'h0000_00FF);
    write_protect_n <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({31'h0, target_inhibit}, 32'h0000_0000);
    $display("unlock test done");
  endtask

  task automatic t_protect();
    write_protect_n <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({31'h0, target_inhibit}, 32'h0000_0001);
    fw(20'h0_0000, 32'h0000_0060);
    fw(20'h1_4000, 32'h0000_00D0);
    repeat (2) @(posedge hclk);
    chk({31'h0, target_inhibit}, 32'h0000_0000);
    fw(20'h0_0000, 32'h0000_00FF);
    fw(20'h0_0000, 32'h0000_0090);
    fr(20'h1_4002, r);
    chk(r, 32'h0000_0000);
    fr(20'h0_0005, r);
    chk(r, 32'h0000_5A3C);
    fr(20'h1_8002, r);
    chk(r, 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      fw(20'h0_0000, 32'h0000_00FF);
      fw(20'h0_0000, 32'h0000_0060);
      fw(20'h1_4000, 32'h0000_0001);
    end
    fw(20'h0_0000, 32'h0000_00FF);
    fw(20'h0_0000, 32'h0000_0090);
    fr(20'h1_4002, r);
    chk(r, 32'h0000_0001);
    fw(20'h0_0000, 32'h0000_00FF);
    $display("protect test done");
  endtask

  task automatic t_password();
    seq(8'h48, 64'h0000_00C3_CAFE_0001, b);
    sr_chk(4'b1001);
    fw(20'h0_0000, 32'h0000_00FF);
    seq(8'h78, 64'h0, b);
    sr_chk(4'b1001);
    fw(20'h0_0000, 32'h0000_00FF);
    rp_pulse();
    chk({31'h0, tuning_unlocked}, 32'h0000_0000);
    seq(8'h78, 64'h0, b);
    sr_chk(4'b1100);
    fw(20'h0_0000, 32'h0000_00FF);
    rp_pulse();
    seq(8'h78, 64'h0000_00C3_CAFE_0001, b);
    sr_chk(4'b1001);
    fw(20'h0_0000, 32'h0000_00FF);
    seq(8'h78, 64'h0000_00C3_CAFE_0000, b);
    sr_chk(4'b1100);
    chk({31'h0, tuning_unlocked}, 32'h0000_0000);
    fw(20'h0_0000, 32'h0000_00FF);
    rp_pulse();
    $display("password test done");
  endtask

  task automatic t_abort();
    fw(20'h0_0000, 32'h0000_0078);
    fw(`FCP_TP_ADDR_LO, 32'h0000_0000);
    program_erase_enable_pin <= 1'b0;
    repeat (2) @(posedge hclk);
    fr(20'h0_0000, sr);
    chk({31'h0, sr[3]}, 32'h0000_0001);
    chk({31'h0, tuning_unlocked}, 32'h0000_0000);
    program_erase_enable_pin <= 1'b1;
    fw(20'h0_0000, 32'h0000_0078);
    fw(`FCP_TP_ADDR_LO, 32'h0000_0000);
    rp_pulse();
    fr(20'h0_0000, r);
    chk(r, 32'h1357_9BDF);
    $display("abort test done");
  endtask

  initial begin
    hresetn = 1'b0;
    program_erase_enable_pin = 1'b1;
    reset_powerdown_pin = 1'b1;
    write_protect_n = 1'b0;
    pe_suspended = 1'b0;
    array_rdata = 32'h1357_9BDF;
    target_addr = 20'h1_4000;
    n_errors = 0;
    checks = 0;
    n_res = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_bcr();
    t_resume();
    t_unlock();
    t_protect();
    t_password();
    t_abort();
    final_report();
  end
endmodule // flash_config_protect_commands_bench
